// [core/temp_limit_register_bank.sv]
/*
 * Register bank of a digital temperature sensor: result, identification,
 * limit and hysteresis setpoints, limit comparison, alarm pins, and the
 * four-wire serial slave that reaches the registers.
 * Assumes conversion results arrive on clk as a one-cycle strobe and
 * that the serial clock runs at most at one eighth of clk.
 */
// Functional notes
// - Result held and read as 16-bit word
// - 13-bit mode: bits 2..0 are alarm flags
// - 16-bit mode: bits 2..0 carry extra LSBs
// - Bit 15 sign, bits 14..3 magnitude
// - Identification: maker bits 7..3, revision 2..0
// - Result above critical limit raises critical pin
// - Critical limit read/write, resets to 147 degrees
// - Hysteresis unsigned four bits, one degree steps
// - Hysteresis lowers upper/critical, raises lower release
// - Hysteresis resets to five, top bits zero
// - Result above upper limit raises limit pin
// - Upper limit read/write, resets to 64 degrees
// - Result below lower limit raises limit pin
// - Lower limit read/write, resets to 10 degrees
// - Limits compared as signed values
// - Resolution bit selects 13-bit or 16-bit result
// - Comparator mode releases pin past hysteresis threshold
`timescale 1ns/1ns
`include "temp_limit_cfg.svh"
module temp_limit_register_bank #(
    parameter logic [4:0] MAKER_ID    = 5'h0A, // Arbitrary value
    parameter logic [2:0] REVISION_ID = 3'h1   // Arbitrary value
) (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        conv_valid,
    input  wire logic [15:0] conv_result,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        din,
    output logic             dout,
    output logic             critical_alarm_pin,
    output logic             limit_alarm_pin
);

    logic [2:0]                      pins_sync;
    logic                            sclk_s;
    logic                            cs_n_s;
    logic                            din_s;
    logic                            sclk_d_reg;
    logic                            sclk_rise;
    logic                            sclk_fall;
    temp_limit_pkg::spi_phase_t      phase_reg;
    logic [4:0]                      bit_cnt_reg;
    logic [14:0]                     shin_reg;
    logic [15:0]                     shout_reg;
    logic                            is_read_reg;
    logic [2:0]                      addr_reg;
    logic [`SERIAL_CNT_BITS-1:0]     ones_cnt_reg;
    logic                            soft_rst_reg;
    logic                            wr_stb_reg;
    logic [15:0]                     wr_data_reg;
    logic                            rd_stb_reg;
    logic                            dout_reg;
    temp_limit_pkg::byte_t           config_reg;
    temp_limit_pkg::word_t           result_reg;
    temp_limit_pkg::word_t           crit_limit_reg;
    temp_limit_pkg::byte_t           hysteresis_value_reg;
    temp_limit_pkg::word_t           upper_limit_reg;
    temp_limit_pkg::word_t           lower_limit_reg;
    logic                            crit_state_reg;
    logic                            upper_state_reg;
    logic                            lower_state_reg;
    logic                            int_latch_reg;
    logic                            crit_pin_reg;
    logic                            limit_pin_reg;
    logic                            res16;
    logic                            cmp_mode;
    logic [7:0]                      cmd_byte;
    logic [15:0]                     wr_word;
    logic                            cmd_ok;
    logic                            wide_reg;
    temp_limit_pkg::word_t           new_result;
    logic signed [16:0]              res_x;
    logic signed [16:0]              hyst_x;
    logic signed [16:0]              crit_x;
    logic signed [16:0]              upper_x;
    logic signed [16:0]              lower_x;
    logic                            crit_set;
    logic                            crit_rel;
    logic                            upper_set;
    logic                            upper_rel;
    logic                            lower_set;
    logic                            lower_rel;
    logic                            limit_active;

    pin_sync #(
        .WIDTH (3)
    ) u_pin_sync (
        .clk      (clk),
        .sys_rst  (sys_rst),
        .async_in ({sclk, cs_n, din}),
        .sync_out (pins_sync)
    );

    assign sclk_s    = pins_sync[2];
    assign cs_n_s    = pins_sync[1];
    assign din_s     = pins_sync[0];
    assign sclk_rise = sclk_s & ~sclk_d_reg;
    assign sclk_fall = ~sclk_s & sclk_d_reg;

    assign res16    = config_reg[`CFG_RES16_BIT];
    assign cmp_mode = config_reg[`CFG_CMP_MODE_BIT];
    assign cmd_byte = {shin_reg[6:0], din_s};
    assign wr_word  = {shin_reg, din_s};
    // Bits 7 and 2..0 of a command must be zero, else the frame is dropped
    assign cmd_ok   = ~cmd_byte[7] & (cmd_byte[2:0] == 3'h0);
    assign wide_reg = (addr_reg == `ADDR_RESULT) |
                      (addr_reg == `ADDR_CRIT_LIMIT) |
                      (addr_reg == `ADDR_UPPER_LIMIT) |
                      (addr_reg == `ADDR_LOWER_LIMIT);

    // Read value, 8-bit registers placed in the upper byte for shifting
    function automatic logic [15:0] read_value(input logic [2:0] a);
        logic [15:0] v;
        v = 16'h0000;
        unique case (a)
            `ADDR_STATUS:      v = 16'h0000;
            `ADDR_CONFIG:      v = {config_reg, 8'h00};
            `ADDR_RESULT:      v = res16 ? result_reg :
                                   {result_reg[15:3], crit_state_reg,
                                    upper_state_reg, lower_state_reg};
            `ADDR_IDENT:       v = {MAKER_ID, REVISION_ID, 8'h00};
            `ADDR_CRIT_LIMIT:  v = crit_limit_reg;
            `ADDR_HYST:        v = {hysteresis_value_reg, 8'h00};
            `ADDR_UPPER_LIMIT: v = upper_limit_reg;
            `ADDR_LOWER_LIMIT: v = lower_limit_reg;
        endcase
        return v;
    endfunction

    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            sclk_d_reg <= 1'b0;
        end else begin
            sclk_d_reg <= sclk_s;
        end
    end

    // Serial interface reset after 32 consecutive ones clocked in
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            ones_cnt_reg <= '0;
            soft_rst_reg <= 1'b0;
        end else begin
            soft_rst_reg <= 1'b0;
            if (sclk_rise) begin
                if (!din_s) begin
                    ones_cnt_reg <= '0;
                end else if (ones_cnt_reg == `SERIAL_RESET_ONES - 6'h01) begin
                    ones_cnt_reg <= '0;
                    soft_rst_reg <= 1'b1;
                end else begin
                    ones_cnt_reg <= ones_cnt_reg + 6'h01;
                end
            end
        end
    end

    // Frame engine: command byte, then 8 or 16 data bits
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            phase_reg   <= temp_limit_pkg::PH_CMD;
            bit_cnt_reg <= 5'h00;
            shin_reg    <= 15'h0000;
            shout_reg   <= 16'h0000;
            is_read_reg <= 1'b0;
            addr_reg    <= 3'h0;
            wr_stb_reg  <= 1'b0;
            wr_data_reg <= 16'h0000;
            rd_stb_reg  <= 1'b0;
            dout_reg    <= 1'b0;
        end else begin
            wr_stb_reg <= 1'b0;
            rd_stb_reg <= 1'b0;
            if (cs_n_s || soft_rst_reg) begin
                phase_reg   <= temp_limit_pkg::PH_CMD;
                bit_cnt_reg <= 5'h00;
            end else if (sclk_rise) begin
                shin_reg    <= wr_word[14:0];
                bit_cnt_reg <= bit_cnt_reg + 5'h01;
                unique case (phase_reg)
                    temp_limit_pkg::PH_CMD: begin
                        if (bit_cnt_reg == 5'h07) begin
                            bit_cnt_reg <= 5'h00;
                            is_read_reg <= cmd_byte[`CMD_READ_BIT];
                            addr_reg    <= cmd_byte[`CMD_ADDR_HI:`CMD_ADDR_LO];
                            phase_reg   <= cmd_ok ? temp_limit_pkg::PH_DATA
                                                  : temp_limit_pkg::PH_DONE;
                            if (cmd_ok && cmd_byte[`CMD_READ_BIT]) begin
                                shout_reg  <= read_value(
                                    cmd_byte[`CMD_ADDR_HI:`CMD_ADDR_LO]);
                                rd_stb_reg <= 1'b1;
                            end
                        end
                    end
                    temp_limit_pkg::PH_DATA: begin
                        if (bit_cnt_reg == (wide_reg ? 5'h0F : 5'h07)) begin
                            phase_reg <= temp_limit_pkg::PH_DONE;
                            if (!is_read_reg) begin
                                wr_stb_reg  <= 1'b1;
                                wr_data_reg <= wr_word;
                            end
                        end
                    end
                    temp_limit_pkg::PH_DONE: begin
                        bit_cnt_reg <= bit_cnt_reg;
                    end
                endcase
            end else if (sclk_fall && is_read_reg &&
                         phase_reg == temp_limit_pkg::PH_DATA) begin
                dout_reg  <= shout_reg[15];
                shout_reg <= {shout_reg[14:0], 1'b0};
            end
        end
    end

    // Setpoint and configuration registers
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            config_reg           <= `RST_CONFIG;
            crit_limit_reg       <= `RST_CRIT_LIMIT;
            hysteresis_value_reg <= `RST_HYST;
            upper_limit_reg      <= `RST_UPPER_LIMIT;
            lower_limit_reg      <= `RST_LOWER_LIMIT;
        end else if (soft_rst_reg) begin
            config_reg           <= `RST_CONFIG;
            crit_limit_reg       <= `RST_CRIT_LIMIT;
            hysteresis_value_reg <= `RST_HYST;
            upper_limit_reg      <= `RST_UPPER_LIMIT;
            lower_limit_reg      <= `RST_LOWER_LIMIT;
        end else if (wr_stb_reg) begin
            // 8-bit writes arrive in the low byte of the assembled word
            unique case (addr_reg)
                `ADDR_CONFIG:      config_reg <= wr_data_reg[7:0];
                `ADDR_CRIT_LIMIT:  crit_limit_reg <= wr_data_reg;
                `ADDR_HYST:        hysteresis_value_reg <= wr_data_reg[7:0];
                `ADDR_UPPER_LIMIT: upper_limit_reg <= wr_data_reg;
                `ADDR_LOWER_LIMIT: lower_limit_reg <= wr_data_reg;
                default: ;
            endcase
        end
    end

    // 13-bit mode drops the three extended LSBs of the conversion
    assign new_result = res16 ? conv_result :
                        {conv_result[15:3], 3'h0};
    // Signed 17-bit arithmetic so thresholds never wrap
    assign res_x   = {new_result[`RES_SIGN_BIT], new_result};
    assign crit_x  = {crit_limit_reg[15], crit_limit_reg};
    assign upper_x = {upper_limit_reg[15], upper_limit_reg};
    assign lower_x = {lower_limit_reg[15], lower_limit_reg};
    // One degree is the same word weight in both resolutions
    assign hyst_x  = {6'h00, hysteresis_value_reg[`HYST_BITS-1:0], 7'h00};

    assign crit_set  = res_x > crit_x;
    assign crit_rel  = res_x < (crit_x - hyst_x);
    assign upper_set = res_x > upper_x;
    assign upper_rel = res_x < (upper_x - hyst_x);
    assign lower_set = res_x < lower_x;
    assign lower_rel = res_x > (lower_x + hyst_x);
    // Result and alarm states move only on a new conversion or a serial interface reset
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            result_reg      <= `RST_RESULT;
            crit_state_reg  <= 1'b0;
            upper_state_reg <= 1'b0;
            lower_state_reg <= 1'b0;
        end else if (soft_rst_reg) begin
            result_reg      <= `RST_RESULT;
            crit_state_reg  <= 1'b0;
            upper_state_reg <= 1'b0;
            lower_state_reg <= 1'b0;
        end else if (conv_valid) begin
            result_reg <= new_result;
            if (crit_set) begin
                crit_state_reg <= 1'b1;
            end else if (crit_rel) begin
                crit_state_reg <= 1'b0;
            end
            if (upper_set) begin
                upper_state_reg <= 1'b1;
            end else if (upper_rel) begin
                upper_state_reg <= 1'b0;
            end
            if (lower_set) begin
                lower_state_reg <= 1'b1;
            end else if (lower_rel) begin
                lower_state_reg <= 1'b0;
            end
        end
    end

    // Interrupt mode latch: cleared by any read or by shutdown
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            int_latch_reg <= 1'b0;
        end else if (soft_rst_reg) begin
            int_latch_reg <= 1'b0;
        end else if (conv_valid && (upper_set || lower_set)) begin
            // A new event wins over a read in the same cycle
            int_latch_reg <= 1'b1;
        end else if (rd_stb_reg ||
                     config_reg[`CFG_OPMODE_HI:`CFG_OPMODE_LO] ==
                     `OPMODE_SHUTDOWN) begin
            int_latch_reg <= 1'b0;
        end
    end

    assign limit_active = cmp_mode ? (upper_state_reg | lower_state_reg)
                                   : int_latch_reg;
    // Polarity bit 1 means active high
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            crit_pin_reg  <= 1'b1;
            limit_pin_reg <= 1'b1;
        end else begin
            crit_pin_reg  <= ~(crit_state_reg ^
                               config_reg[`CFG_CRIT_POL_BIT]);
            limit_pin_reg <= ~(limit_active ^
                               config_reg[`CFG_LIMIT_POL_BIT]);
        end
    end

    assign dout               = dout_reg;
    assign critical_alarm_pin = crit_pin_reg;
    assign limit_alarm_pin    = limit_pin_reg;
endmodule

// [pkg/temp_limit_cfg.svh]
/*
 * Register offsets, field positions, reset values and serial timing
 * counts of the temperature limit register bank.
 * Assumes inclusion by bare name from the package and the design files.
 */
`ifndef TEMP_LIMIT_CFG_SVH
`define TEMP_LIMIT_CFG_SVH

// Register addresses as carried in command bits 5..3
`define ADDR_STATUS          3'h0
`define ADDR_CONFIG          3'h1
`define ADDR_RESULT          3'h2
`define ADDR_IDENT           3'h3
`define ADDR_CRIT_LIMIT      3'h4
`define ADDR_HYST            3'h5
`define ADDR_UPPER_LIMIT     3'h6
`define ADDR_LOWER_LIMIT     3'h7

// Reset values
`define RST_CONFIG           8'h00
`define RST_RESULT           16'h0000
`define RST_CRIT_LIMIT       16'h4980
`define RST_HYST             8'h05
`define RST_UPPER_LIMIT      16'h2000
`define RST_LOWER_LIMIT      16'h0500

// Configuration register fields
`define CFG_CRIT_POL_BIT     2
`define CFG_LIMIT_POL_BIT    3
`define CFG_CMP_MODE_BIT     4
`define CFG_OPMODE_LO        5
`define CFG_OPMODE_HI        6
`define CFG_RES16_BIT        7
`define OPMODE_SHUTDOWN      2'h3

// Result word fields
`define RES_SIGN_BIT         15
`define RES_FLAG_CRIT        2
`define RES_FLAG_UPPER       1
`define RES_FLAG_LOWER       0

// Hysteresis field width and its scale: one degree is 2**7 result LSBs
`define HYST_BITS            4
`define HYST_SHIFT           7

// Command byte fields
`define CMD_READ_BIT         6
`define CMD_ADDR_HI          5
`define CMD_ADDR_LO          3

// Serial interface reset: consecutive ones on the data input
`define SERIAL_RESET_ONES    6'h20
`define SERIAL_CNT_BITS      6

`endif

// [pkg/temp_limit_pkg.sv]
/*
 * Types shared by the temperature limit register bank.
 * Assumes temp_limit_cfg.svh for the numeric constants.
 */
package temp_limit_pkg;

    // Serial frame phase, Gray coded along command -> data -> done
    typedef enum logic [1:0] {
        PH_CMD  = 2'h0,
        PH_DATA = 2'h1,
        PH_DONE = 2'h3
    } spi_phase_t;

    typedef logic [15:0] word_t;
    typedef logic [7:0]  byte_t;

endpackage

// [core/pin_sync.sv]
/*
 * Two flip-flop synchroniser for a group of independent level inputs.
 * Assumes each bit is a slow level or a clock far below clk.
 */
`timescale 1ns/1ns
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk,
    input  wire logic             sys_rst,
    input  wire logic [WIDTH-1:0] async_in,
    output logic      [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_reg;

    // First stage feeds only the second stage
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            meta_reg <= '0;
            sync_out <= '0;
        end else begin
            meta_reg <= async_in;
            sync_out <= meta_reg;
        end
    end

endmodule

// [tb/temp_limit_register_bank_asserts.sv]
/*
 * Port-level checker for the temperature limit register bank.
 * Assumes the bind below, one clock domain and a serial clock that
 * stands still between frames.
 */
`timescale 1ns/1ns
module temp_limit_register_bank_asserts (
    input  wire logic        clk,
    input  wire logic        sys_rst,
    input  wire logic        conv_valid,
    input  wire logic [15:0] conv_result,
    input  wire logic        sclk,
    input  wire logic        cs_n,
    input  wire logic        din,
    input  wire logic        dout,
    input  wire logic        critical_alarm_pin,
    input  wire logic        limit_alarm_pin
);
    logic [3:0] idle_reg;
    logic       idle;

    // Cycles since chip select was last low, saturating
    always_ff @(posedge clk or posedge sys_rst) begin
        if (sys_rst) begin
            idle_reg <= 4'h0;
        end else if (!cs_n) begin
            idle_reg <= 4'h0;
        end else if (idle_reg != 4'hF) begin
            idle_reg <= idle_reg + 4'h1;
        end
    end
    // Register writes land well inside eight cycles of chip select rising
    assign idle = (idle_reg >= 4'h8);

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    property p_rst_outputs;
        disable iff (1'b0)
        sys_rst |-> critical_alarm_pin && limit_alarm_pin && !dout;
    endproperty
    a_rst_outputs: assert property (p_rst_outputs)
        else $error("outputs not at reset levels during reset");

    property p_release_quiet;
        $fell(sys_rst) |-> (critical_alarm_pin && limit_alarm_pin) [*2];
    endproperty
    a_release_quiet: assert property (p_release_quiet)
        else $error("alarm pin active right after reset");

    property p_crit_cause;
        $changed(critical_alarm_pin) |-> $past(conv_valid, 2) || !idle;
    endproperty
    a_crit_cause: assert property (p_crit_cause)
        else $error("critical pin moved without a conversion");

    property p_limit_cause;
        $changed(limit_alarm_pin) |-> $past(conv_valid, 2) || !idle;
    endproperty
    a_limit_cause: assert property (p_limit_cause)
        else $error("limit pin moved without a conversion");

    property p_conv_latency;
        conv_valid && !$past(conv_valid) && idle
            |=> $stable(critical_alarm_pin) && $stable(limit_alarm_pin);
    endproperty
    a_conv_latency: assert property (p_conv_latency)
        else $error("alarm pin moved one cycle after conversion");

    property p_dout_quiet;
        idle |-> $stable(dout);
    endproperty
    a_dout_quiet: assert property (p_dout_quiet)
        else $error("data output moved outside a frame");

    property p_dout_on_fall;
        $changed(dout) |-> !$past(sclk, 2) && !$past(sclk, 3);
    endproperty
    a_dout_on_fall: assert property (p_dout_on_fall)
        else $error("data output moved away from a clock fall");

    property p_dout_held;
        $rose(sclk) |-> ##1 $stable(dout) [*3];
    endproperty
    a_dout_held: assert property (p_dout_held)
        else $error("data output moved after a clock rise");
endmodule

bind temp_limit_register_bank temp_limit_register_bank_asserts
    temp_limit_register_bank_asserts_i (
    .clk(clk), .sys_rst(sys_rst), .conv_valid(conv_valid),
    .conv_result(conv_result), .sclk(sclk), .cs_n(cs_n), .din(din),
    .dout(dout), .critical_alarm_pin(critical_alarm_pin),
    .limit_alarm_pin(limit_alarm_pin));

// [tb/spi_host_model.sv]
/*
 * Serial host model: one command byte plus 8 or 16 data bits, clock
 * idling high, data in set on the fall and data out taken on the rise.
 * Assumes the bench clock on clk and calls to xfer by hierarchy.
 */
`timescale 1ns/1ns
module spi_host_model (
    input  wire logic        clk,
    input  wire logic        dout,
    output logic             sclk,
    output logic             cs_n,
    output logic             din,
    output logic             rd_done,
    output logic [15:0]      rd_data
);
    // Six clk per phase, above the four-cycle minimum
    localparam int HALF = 6;

    initial begin
        sclk = 1'b1;
        cs_n = 1'b1;
        din = 1'b0;
        rd_done = 1'b0;
        rd_data = 16'h0000;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask

    task automatic xfer(input logic [7:0] cmd, input logic [15:0] wdata,
                        input int nbits);
        logic [31:0] frame;
        frame = {cmd, (nbits == 16) ? wdata : {wdata[7:0], 8'h00}, 8'h00};
        rd_data = 16'h0000;
        tick(1);
        cs_n = 1'b0;
        for (int i = 0; i < 8 + nbits; i++) begin
            tick(HALF);
            sclk = 1'b0;
            din = frame[31-i];
            tick(HALF);
            sclk = 1'b1;
            if (i >= 8) begin
                rd_data = {rd_data[14:0], dout};
            end
        end
        tick(HALF);
        cs_n = 1'b1;
        // Released line toggles so no stale level passes for data
        din = ~din;
        rd_done = cmd[6];
        tick(1);
        rd_done = 1'b0;
        tick(8);
    endtask
endmodule

// [tb/temp_limit_register_bank_tb_top.sv]
/*
 * Self-checking bench: register reset values and access, result flags,
 * hysteresis, alarm pins in both resolutions and polarities.
 * Assumes spi_host_model on the serial pins and the bound checker.
 */
`timescale 1ns/1ns
module temp_limit_register_bank_tb_top;
    localparam logic [4:0] MAKER = 5'h15; // Arbitrary value
    localparam logic [2:0] REV   = 3'h6;  // Arbitrary value
    logic        clk, sys_rst, conv_valid, probe;
    logic [15:0] conv_result, rd_data, seen, v;
    logic        sclk, cs_n, din, dout, crit_pin, lim_pin, rd_done;
    logic [15:0] exp_q[$];
    string       name_q[$];
    int          miscompares, comparisons, i;
    logic [15:0] crit_m, up_m, lo_m, res_m;
    logic [7:0]  hyst_m, cfg_m;
    logic        cst, ust, lst;
    logic [15:0] temps[12] = '{16'h1000, 16'h2100, 16'h1F00, 16'h1D00,
        16'h4A00, 16'h4900, 16'h4600, 16'h1000, 16'h0400, 16'h0600,
        16'h0800, 16'hF000};

    temp_limit_register_bank #(.MAKER_ID(MAKER), .REVISION_ID(REV))
        temp_limit_register_bank_i (
        .clk(clk), .sys_rst(sys_rst), .conv_valid(conv_valid),
        .conv_result(conv_result), .sclk(sclk), .cs_n(cs_n), .din(din),
        .dout(dout), .critical_alarm_pin(crit_pin),
        .limit_alarm_pin(lim_pin));
    spi_host_model spi_host_model_i (
        .clk(clk), .dout(dout), .sclk(sclk), .cs_n(cs_n), .din(din),
        .rd_done(rd_done), .rd_data(rd_data));

    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    task automatic final_report();
        // A note that was never answered counts against the run
        miscompares += exp_q.size();
        $display("Comparisons %0d, mismatches %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    function automatic logic upd(logic st, logic set, logic clr);
        return set ? 1'b1 : (clr ? 1'b0 : st);
    endfunction

    task automatic note(input logic [15:0] e, input string n);
        exp_q.push_back(e);
        name_q.push_back(n);
    endtask

    task automatic rd(input logic [2:0] a, input int nb, input logic [15:0] e);
        note(e, $sformatf("register %0d", a));
        spi_host_model_i.xfer({2'h1, a, 3'h0}, 16'h0000, nb);
    endtask

    task automatic wr(input logic [2:0] a, input int nb, input logic [15:0] d);
        spi_host_model_i.xfer({2'h0, a, 3'h0}, d, nb);
        case (a)
            3'h1: cfg_m = d[7:0];
            3'h4: crit_m = d;
            3'h5: hyst_m = d[7:0];
            3'h6: up_m = d;
            3'h7: lo_m = d;
            default: ;
        endcase
    endtask

    task automatic conv(input logic [15:0] r);
        logic [15:0] h;
        logic [15:0] s;
        logic        l;
        h = {5'h00, hyst_m[3:0], 7'h00};
        s = cfg_m[7] ? r : {r[15:3], 3'h0};
        cst = upd(cst, $signed(s) > $signed(crit_m),
                  $signed(s) < $signed(crit_m - h));
        ust = upd(ust, $signed(s) > $signed(up_m),
                  $signed(s) < $signed(up_m - h));
        lst = upd(lst, $signed(s) < $signed(lo_m),
                  $signed(s) > $signed(lo_m + h));
        // Interrupt mode: the read closing each conv clears the latch
        l = cfg_m[4] ? (ust | lst) : ($signed(s) > $signed(up_m) ||
                                      $signed(s) < $signed(lo_m));
        res_m = cfg_m[7] ? r : {r[15:3], cst, ust, lst};
        conv_valid = 1'b1;
        conv_result = r;
        @(posedge clk);
        #1;
        conv_valid = 1'b0;
        conv_result = 16'($urandom);
        repeat (4) @(posedge clk);
        #1;
        note({14'h0000, cfg_m[2] ~^ cst, cfg_m[3] ~^ l}, "pins");
        probe = 1'b1;
        @(posedge clk);
        #1;
        probe = 1'b0;
        rd(3'h2, 16, res_m);
    endtask

    // Takes the oldest note whenever a read or a pin probe completes
    always @(posedge clk) begin
        if (rd_done === 1'b1 || probe === 1'b1) begin
            seen = probe ? {14'h0000, crit_pin, lim_pin} : rd_data;
            if (exp_q.size() == 0) begin
                miscompares++;
                $display("Error: unplanned expected none seen %h", seen);
            end else begin
                comparisons++;
                if (seen !== exp_q[0]) begin
                    miscompares++;
                    $display("Error: %s expected %h seen %h", name_q[0],
                             exp_q[0], seen);
                end
                void'(exp_q.pop_front());
                void'(name_q.pop_front());
            end
        end
    end

    initial begin
        repeat (40000) @(posedge clk);
        miscompares++;
        $display("Error: run expected done seen timeout");
        final_report();
    end

    initial begin
        sys_rst = 1'b0;
        conv_valid = 1'b0;
        conv_result = 16'h0000;
        probe = 1'b0;
        miscompares = 0;
        comparisons = 0;
        {crit_m, up_m, lo_m, res_m} = {16'h4980, 16'h2000, 16'h0500, 16'h0000};
        hyst_m = 8'h05;
        cfg_m = 8'h00;
        {cst, ust, lst} = 3'h0;
        void'($urandom(70539));
        // Rising reset off time zero so the async reset is seen
        #1;
        sys_rst = 1'b1;
        repeat (16) @(posedge clk);
        #1;
        sys_rst = 1'b0;
        rd(3'h4, 16, 16'h4980);
        rd(3'h5, 8, 16'h0005);
        rd(3'h6, 16, 16'h2000);
        rd(3'h7, 16, 16'h0500);
        rd(3'h3, 8, {8'h00, MAKER, REV});
        $display("Test reset_values done");
        for (i = 4; i < 8; i++) begin
            v = (i == 5) ? {8'h00, 8'($urandom)} : 16'($urandom);
            wr(3'(i), (i == 5) ? 8 : 16, v);
            rd(3'(i), (i == 5) ? 8 : 16, v);
        end
        wr(3'h2, 16, 16'hA5A5);
        rd(3'h2, 16, res_m);
        wr(3'h3, 8, 16'h00FF);
        rd(3'h3, 8, {8'h00, MAKER, REV});
        spi_host_model_i.xfer(8'h31, 16'h1234, 16);
        spi_host_model_i.xfer(8'hB0, 16'h1234, 16);
        rd(3'h6, 16, up_m);
        $display("Test register_access done");
        wr(3'h4, 16, 16'h4980);
        wr(3'h5, 8, 16'h0005);
        wr(3'h6, 16, 16'h2000);
        wr(3'h7, 16, 16'h0500);
        wr(3'h1, 8, 16'h0010);
        foreach (temps[k]) conv(temps[k]);
        repeat (8) conv(16'($urandom));
        $display("Test limits_13bit done");
        wr(3'h1, 8, 16'h009C);
        repeat (6) conv(16'($urandom));
        wr(3'h1, 8, 16'h008C);
        repeat (4) conv(16'($urandom));
        $display("Test limits_16bit done");
        final_report();
    end
endmodule
